// *** rtl/dma_pkg.sv ***
// Behaviour
// (RULE1) Data pin selector: pin 0-31, port 0-1, bit 31 high means disconnected.
// (RULE2) Software loads word-aligned RAM start pointers, separate for receive and transmit.
// (RULE3) Each channel moves at most its byte-limit register count of bytes.
// (RULE4) Moved-byte count register is refreshed when the transfer ends.
// (RULE5) Moved-byte count register is also refreshed on every pattern hit.
// (RULE6) With abort-on-fault set, a bus fault ends the ongoing transfer at once.
// (RULE7) Each channel captures the address of the latest faulting access.
// (RULE8) Four pattern filters, enabled by config bits 0-3, reset zero.
// (RULE9) Config bits 4-7 pick continuous or one-shot (until next word) per filter.
// (RULE10) One-shot filters with external shortcuts can detect consecutive sequences; this block has no shortcut inputs, only a config write re-enables a filter.
// (RULE11) Enabled filter raises its numbered hit when received data equals its pattern word.
// (RULE12) Pattern words written mid-transfer take effect after a hit or transfer end.
// (RULE13) Receive bytes go to consecutive addresses from the pointer, ending at the limit.
package dma_pkg;

  // ===========================================================================
  // Register map (byte offsets)
  // ===========================================================================
  localparam logic [11:0] OFS_TASKS        = 12'h000;
  localparam logic [11:0] OFS_INT_STATUS   = 12'h300;
  localparam logic [11:0] OFS_INT_MASK     = 12'h304;
  localparam logic [11:0] OFS_CHAN_STATUS  = 12'h400;
  localparam logic [11:0] OFS_PIN_SELECT   = 12'h604;
  localparam logic [11:0] OFS_RX_PTR       = 12'h704;
  localparam logic [11:0] OFS_RX_LIMIT     = 12'h708;
  localparam logic [11:0] OFS_RX_MOVED     = 12'h70C;
  localparam logic [11:0] OFS_RX_ABORT     = 12'h71C;
  localparam logic [11:0] OFS_RX_FAULT     = 12'h720;
  localparam logic [11:0] OFS_MATCH_CFG    = 12'h724;
  localparam logic [11:0] OFS_PATTERN_BASE = 12'h728;
  localparam logic [11:0] OFS_PATTERN_STEP = 12'h004;
  localparam logic [11:0] OFS_TX_PTR       = 12'h73C;
  localparam logic [11:0] OFS_TX_LIMIT     = 12'h740;
  localparam logic [11:0] OFS_TX_MOVED     = 12'h744;
  localparam logic [11:0] OFS_TX_ABORT     = 12'h754;
  localparam logic [11:0] OFS_TX_FAULT     = 12'h758;

  // ===========================================================================
  // Fields and reset values
  // ===========================================================================
  localparam int          CNT_W          = 16;
  localparam int          NUM_FILTERS    = 4;
  localparam logic [31:0] PIN_SEL_RESET  = 32'hFFFFFFFF;
  localparam logic [31:0] ZERO_RESET     = 32'h00000000;
  localparam int          TASK_START_RX  = 0;
  localparam int          TASK_START_TX  = 1;
  localparam int          TASK_STOP_RX   = 2;
  localparam int          TASK_STOP_TX   = 3;
  localparam int          TASK_DISABLE_LSB = 8;
  localparam int          CFG_ENABLE_LSB = 0;
  localparam int          CFG_ONESHOT_LSB = 4;

  // Event bits of the interrupt status and mask registers
  localparam int          NUM_EV         = 10;
  localparam int          EV_RX_END      = 0;
  localparam int          EV_RX_STARTED  = 1;
  localparam int          EV_RX_FAULT    = 2;
  localparam int          EV_MATCH_LSB   = 3;
  localparam int          EV_TX_END      = 7;
  localparam int          EV_TX_STARTED  = 8;
  localparam int          EV_TX_FAULT    = 9;

  // ===========================================================================
  // Types
  // ===========================================================================
  typedef struct packed {
    logic        disconnect;
    logic [24:0] unused;
    logic        port;
    logic [4:0]  pin;
  } pin_select_t;

  typedef struct packed {
    logic [31:0] addr;
    logic        write;
    logic [7:0]  wbyte;
  } mem_cmd_t;

  typedef enum logic [1:0] {RX_IDLE, RX_WAIT, RX_STORE} rx_state_t;
  typedef enum logic [1:0] {TX_IDLE, TX_FETCH, TX_SEND} tx_state_t;

endpackage : dma_pkg

// *** rtl/serial_slave_dma_channel.sv ***
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
module serial_slave_dma_channel
  import dma_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  // AHB-Lite register slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  // RAM access port
  output logic                   mem_req,
  output mem_cmd_t               mem_cmd,
  input  wire logic              mem_ready,
  input  wire logic [7:0]        mem_rbyte,
  input  wire logic              mem_fault,
  // Byte stream from the serial slave receiver
  input  wire logic              rx_valid,
  input  wire logic [7:0]        rx_byte,
  output logic                   rx_ready,
  // Byte stream to the serial slave transmitter
  output logic                   tx_valid,
  output logic      [7:0]        tx_byte,
  input  wire logic              tx_ready,
  // Pin routing and interrupt
  output pin_select_t            sda_select,
  output logic                   irq
);

  // ===========================================================================
  // Helpers
  // ===========================================================================
  function automatic logic word_match(input logic [7:0] data, input logic [31:0] word);
    word_match = ({24'h000000, data} == word);
  endfunction : word_match

  function automatic logic [31:0] widen(input logic [CNT_W-1:0] value);
    widen = {{(32-CNT_W){1'b0}}, value};
  endfunction : widen

  // ===========================================================================
  // Declarations
  // ===========================================================================
  logic              dp_valid, dp_write, wr_en;
  logic [11:0]       dp_addr;
  logic [31:0]       pin_select;
  logic [31:0]       rx_ptr, rx_fault_addr;
  logic [CNT_W-1:0]  rx_limit, rx_moved;
  logic              rx_abort_on_fault;
  logic [7:0]        match_cfg;
  logic [31:0]       pattern_word [NUM_FILTERS];
  logic [31:0]       live_word [NUM_FILTERS];
  logic [NUM_FILTERS-1:0] word_pending;
  logic [31:0]       tx_ptr, tx_fault_addr;
  logic [CNT_W-1:0]  tx_limit, tx_moved;
  logic              tx_abort_on_fault;
  logic [NUM_EV-1:0] int_status;
  logic [NUM_EV-1:0] int_mask;
  logic [NUM_EV-1:0] events;

  rx_state_t         rx_state;
  logic [31:0]       rx_addr;
  logic [CNT_W-1:0]  rx_cnt, rx_lim;
  logic [7:0]        rx_hold;
  tx_state_t         tx_state;
  logic [31:0]       tx_addr;
  logic [CNT_W-1:0]  tx_cnt, tx_lim;
  logic [7:0]        tx_hold;

  logic              task_wr, start_rx, start_tx, stop_rx, stop_tx;
  logic              rx_want, tx_want, tx_owns, tx_grant, rx_grant;
  logic              rx_done, rx_fault_ev, rx_end_ev, rx_accept;
  logic [NUM_FILTERS-1:0] hit;
  logic              tx_done, tx_fault_ev, tx_abort, tx_step, tx_end_ev;

  // ===========================================================================
  // AHB-Lite slave: zero wait states, always OKAY
  // ===========================================================================
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr  <= 12'h000;
    end else if (hready) begin
      dp_valid <= hsel & htrans[1];
      dp_write <= hwrite;
      dp_addr  <= haddr[11:0];
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign wr_en     = dp_valid & dp_write;
  assign task_wr   = wr_en && (dp_addr == OFS_TASKS);

  // Read mux works on the latched address so a read right after a write sees new data
  always_comb begin
    hrdata = 32'h00000000;
    if (dp_valid && !dp_write) begin
      unique case (dp_addr)
        OFS_INT_STATUS:  hrdata = {{(32-NUM_EV){1'b0}}, int_status};
        OFS_INT_MASK:    hrdata = {{(32-NUM_EV){1'b0}}, int_mask};
        OFS_CHAN_STATUS: hrdata = {30'h00000000, tx_state != TX_IDLE, rx_state != RX_IDLE};
        OFS_PIN_SELECT:  hrdata = pin_select;
        OFS_RX_PTR:      hrdata = rx_ptr;
        OFS_RX_LIMIT:    hrdata = widen(rx_limit);
        OFS_RX_MOVED:    hrdata = widen(rx_moved);
        OFS_RX_ABORT:    hrdata = {31'h00000000, rx_abort_on_fault};
        OFS_RX_FAULT:    hrdata = rx_fault_addr;
        OFS_MATCH_CFG:   hrdata = {24'h000000, match_cfg};
        OFS_TX_PTR:      hrdata = tx_ptr;
        OFS_TX_LIMIT:    hrdata = widen(tx_limit);
        OFS_TX_MOVED:    hrdata = widen(tx_moved);
        OFS_TX_ABORT:    hrdata = {31'h00000000, tx_abort_on_fault};
        OFS_TX_FAULT:    hrdata = tx_fault_addr;
        default: begin
          for (int i = 0; i < NUM_FILTERS; i++) begin
            if (dp_addr == OFS_PATTERN_BASE + 12'(i) * OFS_PATTERN_STEP) begin
              hrdata = pattern_word[i];
            end
          end
        end
      endcase
    end
  end

  // ===========================================================================
  // Plain configuration registers
  // ===========================================================================
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pin_select        <= PIN_SEL_RESET;
      rx_ptr            <= ZERO_RESET;
      rx_limit          <= '0;
      rx_abort_on_fault <= 1'b0;
      tx_ptr            <= ZERO_RESET;
      tx_limit          <= '0;
      tx_abort_on_fault <= 1'b0;
      int_mask          <= '0;
    end else if (wr_en) begin
      unique case (dp_addr)
        OFS_PIN_SELECT: pin_select        <= hwdata; // (RULE1)
        OFS_RX_PTR:     rx_ptr            <= hwdata; // (RULE2)
        OFS_RX_LIMIT:   rx_limit          <= hwdata[CNT_W-1:0];
        OFS_RX_ABORT:   rx_abort_on_fault <= hwdata[0];
        OFS_TX_PTR:     tx_ptr            <= hwdata;
        OFS_TX_LIMIT:   tx_limit          <= hwdata[CNT_W-1:0];
        OFS_TX_ABORT:   tx_abort_on_fault <= hwdata[0];
        OFS_INT_MASK:   int_mask          <= hwdata[NUM_EV-1:0];
        default: ;
      endcase
    end
  end

  assign sda_select = pin_select_t'(pin_select); // (RULE1)

  // ===========================================================================
  // Tasks and RAM port arbitration
  // ===========================================================================
  assign start_rx = task_wr & hwdata[TASK_START_RX];
  assign start_tx = task_wr & hwdata[TASK_START_TX];
  assign stop_rx  = task_wr & hwdata[TASK_STOP_RX];
  assign stop_tx  = task_wr & hwdata[TASK_STOP_TX];

  assign rx_want  = (rx_state == RX_STORE);
  assign tx_want  = (tx_state == TX_FETCH) && (tx_lim != '0);
  // An access in flight keeps its owner, so the receiver cannot cut in mid-access
  assign tx_grant = tx_want && (!rx_want || tx_owns);
  assign rx_grant = rx_want && !tx_grant;
  assign mem_req  = rx_grant | tx_grant;

  always_comb begin
    mem_cmd = '0;
    if (rx_grant) begin
      mem_cmd = '{addr: rx_addr, write: 1'b1, wbyte: rx_hold}; // (RULE13)
    end else if (tx_grant) begin
      mem_cmd = '{addr: tx_addr, write: 1'b0, wbyte: 8'h00};
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tx_owns <= 1'b0;
    end else begin
      tx_owns <= tx_grant & ~mem_ready;
    end
  end

  // ===========================================================================
  // Receive channel
  // ===========================================================================
  assign rx_ready    = (rx_state == RX_WAIT) && (rx_lim != '0);
  assign rx_accept   = rx_ready & rx_valid;
  assign rx_done     = rx_grant & mem_ready;
  assign rx_fault_ev = rx_done & mem_fault;
  assign rx_end_ev   = (rx_state != RX_IDLE) &&
                       (stop_rx || (rx_fault_ev && rx_abort_on_fault) ||           // (RULE6)
                        (rx_done && CNT_W'(rx_cnt + 1'b1) == rx_lim) ||             // (RULE3)
                        (rx_state == RX_WAIT && rx_lim == '0));

  always_comb begin
    for (int i = 0; i < NUM_FILTERS; i++) begin
      hit[i] = rx_accept && match_cfg[CFG_ENABLE_LSB + i] &&
               word_match(rx_byte, live_word[i]); // (RULE11)
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rx_state <= RX_IDLE;
      rx_addr  <= ZERO_RESET;
      rx_cnt   <= '0;
      rx_lim   <= '0;
      rx_hold  <= 8'h00;
    end else if (rx_end_ev) begin
      rx_state <= RX_IDLE;
    end else begin
      unique case (rx_state)
        RX_IDLE: begin
          if (start_rx) begin
            rx_addr  <= rx_ptr; // (RULE13)
            rx_cnt   <= '0;
            rx_lim   <= rx_limit; // (RULE3)
            rx_state <= RX_WAIT;
          end
        end
        RX_WAIT: begin
          if (rx_accept) begin
            rx_hold  <= rx_byte;
            rx_state <= RX_STORE;
          end
        end
        RX_STORE: begin
          if (rx_done) begin
            rx_addr  <= rx_addr + 32'h00000001; // (RULE13)
            rx_cnt   <= CNT_W'(rx_cnt + 1'b1);
            rx_state <= RX_WAIT;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rx_moved <= '0;
    end else if (rx_end_ev) begin
      rx_moved <= rx_done ? CNT_W'(rx_cnt + 1'b1) : rx_cnt; // (RULE4)
    end else if (|hit) begin
      rx_moved <= rx_cnt; // (RULE5)
    end
  end

  // Software may also write the fault address; a new fault overwrites it
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rx_fault_addr <= ZERO_RESET;
    end else if (rx_fault_ev) begin
      rx_fault_addr <= rx_addr; // (RULE7)
    end else if (wr_en && dp_addr == OFS_RX_FAULT) begin
      rx_fault_addr <= hwdata;
    end
  end

  // ===========================================================================
  // Pattern matcher
  // ===========================================================================
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      match_cfg <= 8'h00; // (RULE8)
    end else if (wr_en && dp_addr == OFS_MATCH_CFG) begin
      match_cfg <= hwdata[7:0];
    end else begin
      for (int i = 0; i < NUM_FILTERS; i++) begin
        // One-shot filters live only until the next received word
        if (rx_accept && match_cfg[CFG_ONESHOT_LSB + i]) begin
          match_cfg[CFG_ENABLE_LSB + i] <= 1'b0; // (RULE9)
        end
        if (task_wr && hwdata[TASK_DISABLE_LSB + i]) begin
          match_cfg[CFG_ENABLE_LSB + i] <= 1'b0; // (RULE9)
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_FILTERS; i++) begin
        pattern_word[i] <= ZERO_RESET;
        live_word[i]    <= ZERO_RESET;
      end
      word_pending <= '0;
    end else begin
      for (int i = 0; i < NUM_FILTERS; i++) begin
        if ((|hit || rx_end_ev) && word_pending[i]) begin
          live_word[i]    <= pattern_word[i]; // (RULE12)
          word_pending[i] <= 1'b0;
        end
        if (wr_en && dp_addr == OFS_PATTERN_BASE + 12'(i) * OFS_PATTERN_STEP) begin
          pattern_word[i] <= hwdata;
          // A write during a transfer waits, so the search in progress is not disturbed
          if (rx_state == RX_IDLE) begin
            live_word[i] <= hwdata;
          end else begin
            word_pending[i] <= 1'b1; // (RULE12)
          end
        end
      end
    end
  end

  // ===========================================================================
  // Transmit channel
  // ===========================================================================
  assign tx_valid    = (tx_state == TX_SEND);
  assign tx_byte     = tx_hold;
  assign tx_done     = tx_grant & mem_ready;
  assign tx_fault_ev = tx_done & mem_fault;
  assign tx_abort    = tx_fault_ev & tx_abort_on_fault;
  // A faulted fetch without abort skips that byte
  assign tx_step     = (tx_valid && tx_ready) || (tx_fault_ev && !tx_abort_on_fault);
  assign tx_end_ev   = (tx_state != TX_IDLE) &&
                       (stop_tx || tx_abort ||                                  // (RULE6)
                        (tx_step && CNT_W'(tx_cnt + 1'b1) == tx_lim) ||          // (RULE3)
                        (tx_state == TX_FETCH && tx_lim == '0));

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tx_state <= TX_IDLE;
      tx_addr  <= ZERO_RESET;
      tx_cnt   <= '0;
      tx_lim   <= '0;
      tx_hold  <= 8'h00;
    end else if (tx_end_ev) begin
      tx_state <= TX_IDLE;
    end else begin
      unique case (tx_state)
        TX_IDLE: begin
          if (start_tx) begin
            tx_addr  <= tx_ptr;
            tx_cnt   <= '0;
            tx_lim   <= tx_limit; // (RULE3)
            tx_state <= TX_FETCH;
          end
        end
        TX_FETCH: begin
          if (tx_done && !mem_fault) begin
            tx_hold  <= mem_rbyte;
            tx_state <= TX_SEND;
          end
        end
        TX_SEND: ;
      endcase
      if (tx_step) begin
        tx_addr  <= tx_addr + 32'h00000001;
        tx_cnt   <= CNT_W'(tx_cnt + 1'b1);
        tx_state <= TX_FETCH;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tx_moved <= '0;
    end else if (tx_end_ev) begin
      tx_moved <= tx_step ? CNT_W'(tx_cnt + 1'b1) : tx_cnt; // (RULE4)
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tx_fault_addr <= ZERO_RESET;
    end else if (tx_fault_ev) begin
      tx_fault_addr <= tx_addr; // (RULE7)
    end else if (wr_en && dp_addr == OFS_TX_FAULT) begin
      tx_fault_addr <= hwdata;
    end
  end

  // ===========================================================================
  // Interrupts: sticky status, write one to clear, set beats clear
  // ===========================================================================
  always_comb begin
    events                = '0;
    events[EV_RX_END]     = rx_end_ev;
    events[EV_RX_STARTED] = start_rx && rx_state == RX_IDLE;
    events[EV_RX_FAULT]   = rx_fault_ev;
    events[EV_TX_END]     = tx_end_ev;
    events[EV_TX_STARTED] = start_tx && tx_state == TX_IDLE;
    events[EV_TX_FAULT]   = tx_fault_ev;
    for (int i = 0; i < NUM_FILTERS; i++) begin
      events[EV_MATCH_LSB + i] = hit[i]; // (RULE11)
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      int_status <= '0;
    end else if (wr_en && dp_addr == OFS_INT_STATUS) begin
      int_status <= (int_status & ~hwdata[NUM_EV-1:0]) | events;
    end else begin
      int_status <= int_status | events;
    end
  end

  assign irq = |(int_status & int_mask);

endmodule : serial_slave_dma_channel
`default_nettype wire

// *** verification/dma_chk_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
module dma_chk
  import dma_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        mem_req,
  input wire mem_cmd_t    mem_cmd,
  input wire logic        mem_ready,
  input wire logic [7:0]  mem_rbyte,
  input wire logic        mem_fault,
  input wire logic        rx_valid,
  input wire logic [7:0]  rx_byte,
  input wire logic        rx_ready,
  input wire logic        tx_valid,
  input wire logic [7:0]  tx_byte,
  input wire logic        tx_ready,
  input wire pin_select_t sda_select
);
  // ==========
  // Checks
  logic rd_ph;
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst) rd_ph <= 1'b0;
    else rd_ph <= hsel && htrans[1] && hready && !hwrite;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  property p_pin_rst; $rose(nrst) |-> sda_select == 32'hFFFFFFFF; endproperty
  property p_rd_idle; !rd_ph |-> hrdata == 32'h0; endproperty
  property p_cmd_hold; mem_req && !mem_ready |=> mem_req && $stable(mem_cmd); endproperty
  // Port free only: a waiting fetch may delay the store
  property p_store;
    rx_valid && rx_ready && !mem_req |=> mem_req && mem_cmd.write && mem_cmd.wbyte == $past(rx_byte);
  endproperty
  property p_no_take; mem_req && mem_cmd.write |-> !rx_ready; endproperty
  property p_fetch;
    mem_req && !mem_cmd.write && mem_ready && !mem_fault |=> tx_valid && tx_byte == $past(mem_rbyte);
  endproperty
  property p_tx_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte); endproperty
  property p_one_fetch; tx_valid |-> !(mem_req && !mem_cmd.write); endproperty
  a_pin_rst: assert property (p_pin_rst) else $error("pin select reset wrong");
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside data phase");
  a_cmd_hold: assert property (p_cmd_hold) else $error("ram command moved");
  a_store: assert property (p_store) else $error("accepted byte not stored");
  a_no_take: assert property (p_no_take) else $error("byte taken while storing");
  a_fetch: assert property (p_fetch) else $error("fetched byte not offered");
  a_tx_hold: assert property (p_tx_hold) else $error("tx byte dropped");
  a_one_fetch: assert property (p_one_fetch) else $error("fetch while byte pending");
  c_store: cover property (mem_req && mem_ready && mem_cmd.write);
  c_fetch: cover property (tx_valid && tx_ready);
  c_fault: cover property (mem_req && mem_ready && mem_fault);
endmodule : dma_chk
`default_nettype wire

// *** verification/ram_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module ram_model
  import dma_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        mem_req,
  input  wire mem_cmd_t    mem_cmd,
  output logic             mem_ready,
  output logic [7:0]       mem_rbyte,
  output logic             mem_fault,
  input  wire logic        slow,
  input  wire logic [31:0] fault_at
);
  // ==========
  // Byte RAM
  logic [7:0] ram [0:255];
  logic [7:0] junk;
  logic [1:0] waits;
  initial for (int i = 0; i < 256; i++) ram[i] = 8'(i) ^ 8'hA5;
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst) begin
      waits <= 2'h0;
      junk <= 8'h5A;
    end else begin
      waits <= (mem_req && !mem_ready) ? waits + 2'h1 : 2'h0;
      junk <= ~junk;
    end
  assign mem_ready = mem_req && (!slow || waits == 2'h2);
  assign mem_fault = mem_ready && mem_cmd.addr == fault_at;
  // Junk outside an answer exposes use of a stale byte
  assign mem_rbyte = mem_ready ? ram[mem_cmd.addr[7:0]] : junk;
  always @(posedge ref_clk)
    if (mem_ready && mem_cmd.write && !mem_fault) ram[mem_cmd.addr[7:0]] <= mem_cmd.wbyte;
endmodule : ram_model
`default_nettype wire

// *** verification/serial_slave_dma_channel_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module serial_slave_dma_channel_tb
  import dma_pkg::*;
;
  logic ref_clk, nrst, hsel, hwrite, hreadyout, hresp, irq, slow, s_hr, s_rxr;
  logic mem_req, mem_ready, mem_fault, rx_valid, rx_ready, tx_valid, tx_ready;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  mem_rbyte, rx_byte, tx_byte;
  logic [31:0] haddr, hwdata, hrdata, fault_at, s_rd, q;
  mem_cmd_t    mem_cmd;
  pin_select_t sda_select;
  logic [7:0]  txq[$];
  int          err_count, n_compared;
  serial_slave_dma_channel serial_slave_dma_channel_inst (.ref_clk, .nrst, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .mem_req, .mem_cmd, .mem_ready, .mem_rbyte, .mem_fault, .rx_valid, .rx_byte, .rx_ready,
    .tx_valid, .tx_byte, .tx_ready, .sda_select, .irq);
  ram_model ram_model_inst (.ref_clk, .nrst, .mem_req, .mem_cmd, .mem_ready, .mem_rbyte,
    .mem_fault, .slow, .fault_at);
  // ==========
  // Clock and samplers
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    s_rd <= hrdata;
    s_hr <= hreadyout;
    s_rxr <= rx_ready;
    tx_ready <= ~tx_ready;
    if (tx_valid === 1'b1 && tx_ready === 1'b1) txq.push_back(tx_byte);
  end
  // ==========
  // Tasks
  task automatic step();
    @(posedge ref_clk);
    #1;
  endtask : step
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask : chk
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    haddr <= {20'h0, a};
    hwrite <= w;
    do step(); while (s_hr !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do step(); while (s_hr !== 1'b1);
    q = s_rd;
  endtask : bus
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n);
    bus(1'b0, a, 32'h0);
    chk(n, e, q);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : rd
  task automatic put(input logic [7:0] b);
    rx_valid <= 1'b1;
    rx_byte <= b;
    do step(); while (s_rxr !== 1'b1);
    rx_valid <= 1'b0;
    rx_byte <= ~b;
    step();
    while (mem_req === 1'b1) step();
  endtask : put
  task automatic tx_run(input logic [31:0] abort, input logic [31:0] bad);
    wr(OFS_TX_ABORT, abort);
    fault_at <= bad;
    txq.delete();
    wr(OFS_TASKS, 32'h2);
    do bus(1'b0, OFS_CHAN_STATUS, 32'h0); while (q[1] !== 1'b0);
  endtask : tx_run
  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  initial begin
    #400000;
    $display("watchdog expired");
    err_count++;
    conclude();
  end
  // ==========
  // Tests
  initial begin
    {nrst, hsel, hwrite, rx_valid, tx_ready, slow} = 6'h10;
    {htrans, hsize, haddr, hwdata, rx_byte} = {2'h0, 3'h2, 72'h0};
    fault_at = 32'hFFFFFFFF;
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    step();
    rd(OFS_PIN_SELECT, PIN_SEL_RESET, "pin_sel");
    chk("sda_select", PIN_SEL_RESET, sda_select);
    rd(OFS_MATCH_CFG, ZERO_RESET, "match_cfg");
    rd(OFS_RX_PTR, ZERO_RESET, "rx_ptr");
    wr(OFS_PIN_SELECT, 32'h3F);
    rd(OFS_PIN_SELECT, 32'h3F, "pin_sel");
    chk("sda_select", 32'h3F, sda_select);
    rd(12'h7F0, ZERO_RESET, "unmapped");
    $display("test registers done");
    wr(OFS_RX_PTR, 32'h20);
    wr(OFS_RX_LIMIT, 32'h4);
    wr(OFS_PATTERN_BASE, 32'h42);
    wr(OFS_PATTERN_BASE + OFS_PATTERN_STEP, 32'h11);
    wr(OFS_MATCH_CFG, 32'h23);
    wr(OFS_TASKS, 32'h1);
    put(8'h11);
    rd(OFS_RX_MOVED, 32'h0, "moved_hit1");
    rd(OFS_MATCH_CFG, 32'h21, "oneshot");
    wr(OFS_PATTERN_BASE, 32'h77);
    put(8'h42);
    rd(OFS_RX_MOVED, 32'h1, "moved_hit0");
    rd(OFS_INT_STATUS, 32'h1A, "hits");
    wr(OFS_INT_STATUS, 32'h1A);
    put(8'h42);
    rd(OFS_INT_STATUS, 32'h0, "old_word");
    put(8'h77);
    rd(OFS_INT_STATUS, 32'h9, "new_word");
    rd(OFS_RX_MOVED, 32'h4, "moved_end");
    chk("ram", 32'h11424277, {ram_model_inst.ram[32], ram_model_inst.ram[33],
        ram_model_inst.ram[34], ram_model_inst.ram[35]});
    chk("irq_masked", 32'h0, {31'h0, irq});
    wr(OFS_INT_MASK, 32'h1);
    chk("irq", 32'h1, {31'h0, irq});
    wr(OFS_INT_STATUS, 32'h9);
    chk("irq_clr", 32'h0, {31'h0, irq});
    $display("test rx done");
    slow <= 1'b1;
    wr(OFS_TX_PTR, 32'h40);
    wr(OFS_TX_LIMIT, 32'h3);
    tx_run(32'h0, 32'hFFFFFFFF);
    chk("tx_count", 32'h3, 32'(txq.size()));
    for (int i = 0; i < 3; i++) chk("tx_byte", {24'h0, 8'(64 + i) ^ 8'hA5}, {24'h0, txq[i]});
    rd(OFS_TX_MOVED, 32'h3, "tx_moved");
    rd(OFS_INT_STATUS, 32'h180, "tx_events");
    $display("test tx done");
    tx_run(32'h1, 32'h41);
    chk("abort_count", 32'h1, 32'(txq.size()));
    rd(OFS_TX_FAULT, 32'h41, "fault_addr");
    tx_run(32'h0, 32'h42);
    chk("skip_count", 32'h2, 32'(txq.size()));
    rd(OFS_TX_FAULT, 32'h42, "fault_addr2");
    $display("test fault done");
    conclude();
  end
endmodule : serial_slave_dma_channel_tb
bind serial_slave_dma_channel dma_chk dma_chk_inst (.ref_clk, .nrst, .hsel, .htrans, .hwrite,
  .hready, .hrdata, .mem_req, .mem_cmd, .mem_ready, .mem_rbyte, .mem_fault, .rx_valid,
  .rx_byte, .rx_ready, .tx_valid, .tx_byte, .tx_ready, .sda_select);
`default_nettype wire
